// File: rtl/fuse_sig_pkg.sv
package fuse_sig_pkg;

    localparam int FUSE_IDX_W = 4;
    localparam int FUSE_COUNT = 11;
    localparam int PART_ID_BYTES = 3;
    localparam int SERIAL_BYTES = 10;

    // signature row offsets
    localparam logic [5:0] OFS_PART_ID = 6'h00;
    localparam logic [5:0] OFS_SERIAL = 6'h03;
    localparam logic [5:0] OFS_OSC_16M_3V = 6'h22;
    localparam logic [5:0] OFS_OSC_16M_5V = 6'h23;
    localparam logic [5:0] OFS_OSC_20M_3V = 6'h24;
    localparam logic [5:0] OFS_OSC_20M_5V = 6'h25;

    // fuse bank offsets
    localparam logic [3:0] FUSE_WATCHDOG = 4'h0;
    localparam logic [3:0] FUSE_BROWNOUT = 4'h1;
    localparam logic [3:0] FUSE_OSC = 4'h2;
    localparam logic [3:0] FUSE_SYS_A = 4'h5;
    localparam logic [3:0] FUSE_SYS_B = 4'h6;
    localparam logic [3:0] FUSE_APP_END = 4'h7;
    localparam logic [3:0] FUSE_BOOT_END = 4'h8;
    localparam logic [3:0] FUSE_LOCK = 4'ha;

    // fixed values
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [7:0] FUSE_ERASED = 8'hff;
    localparam logic [7:0] WATCHDOG_FUSE_RST = 8'h00;
    localparam logic [7:0] BROWNOUT_FUSE_RST = 8'h00;
    localparam logic [7:0] OSC_FUSE_RST = 8'h02;
    localparam logic [7:0] SYS_A_FUSE_RST = 8'hc4;
    localparam logic [7:0] SYS_B_FUSE_RST = 8'h07;
    localparam logic [7:0] PLAIN_FUSE_RST = 8'h00;

    // brown-out codes
    localparam logic [2:0] BOD_LVL_1V8 = 3'h0;
    localparam logic [2:0] BOD_LVL_2V6 = 3'h2;
    localparam logic [2:0] BOD_LVL_4V2 = 3'h7;
    localparam logic BOD_RATE_125HZ = 1'b1;
    localparam logic [1:0] BOD_MODE_OFF = 2'h0;
    localparam logic [1:0] BOD_MODE_ON = 2'h1;
    localparam logic [1:0] BOD_MODE_SAMPLED = 2'h2;
    localparam logic [1:0] BOD_MODE_HOLD = 2'h3;

    typedef logic [7:0] byte_t;
    typedef struct packed {logic [3:0] window; logic [3:0] period;} wdt_cfg_s;
    typedef struct packed {logic [2:0] level; logic sample_rate; logic [1:0] active; logic [1:0] sleep;} bod_fuse_s;
    typedef struct packed {logic sample_rate; logic [1:0] active; logic [1:0] sleep;} bod_first_s;
    typedef enum logic {SPACE_SIG, SPACE_FUSE} space_e;
    typedef struct packed {space_e space; logic [5:0] addr;} byte_req_s;
    typedef enum logic [1:0] {ST_LOAD_WDT, ST_LOAD_BOD, ST_READY} load_e;

    function automatic logic fuse_mapped(input logic [3:0] idx);
        return idx inside {FUSE_WATCHDOG, FUSE_BROWNOUT, FUSE_OSC, FUSE_SYS_A, FUSE_SYS_B,
                           FUSE_APP_END, FUSE_BOOT_END, FUSE_LOCK};
    endfunction

    function automatic byte_t fuse_default(input logic [3:0] idx);
        if (idx == FUSE_WATCHDOG) return WATCHDOG_FUSE_RST;
        if (idx == FUSE_BROWNOUT) return BROWNOUT_FUSE_RST;
        if (idx == FUSE_OSC) return OSC_FUSE_RST;
        if (idx == FUSE_SYS_A) return SYS_A_FUSE_RST;
        if (idx == FUSE_SYS_B) return SYS_B_FUSE_RST;
        return PLAIN_FUSE_RST;
    endfunction

endpackage

// File: rtl/fuse_store.sv
`timescale 1ns/100ps
module fuse_store (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic por_n,
    // programming writes
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire fuse_sig_pkg::byte_t wr_data,
    input wire logic erase,
    // stored bytes and status
    output fuse_sig_pkg::byte_t fuse_q [fuse_sig_pkg::FUSE_COUNT],
    output logic done_q,
    output logic refused_q
);

    wire wr_mapped = fuse_sig_pkg::fuse_mapped(wr_idx);
    wire wr_take = wr_en & wr_mapped & ~erase;

    // contents survive system reset; only power-on brings back the defaults
    for (genvar i = 0; i < fuse_sig_pkg::FUSE_COUNT; i++) begin : g_byte
        localparam logic [3:0] IDX = fuse_sig_pkg::FUSE_IDX_W'(i);
        localparam fuse_sig_pkg::byte_t RST = fuse_sig_pkg::fuse_default(IDX);
        always_ff @(posedge ref_clk or negedge por_n) begin
            if (!por_n) begin
                fuse_q[i] <= RST;
            end else if (erase) begin
                fuse_q[i] <= fuse_sig_pkg::FUSE_ERASED; // [R14]
            end else if (wr_take && wr_idx == IDX) begin
                fuse_q[i] <= wr_data; // [R14]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            done_q <= erase | wr_take;
            refused_q <= wr_en & ~wr_mapped & ~erase;
        end
    end

endmodule

// File: rtl/signature_fuse_loader.sv
`timescale 1ns/100ps
// Function
// R1: three read-only part identifier bytes from signature offset zero upward.
// R2: ten read-only serial bytes from signature offset three, one per offset.
// R3: offset 0x22 reads signed oscillator error, 16 MHz at 3 V.
// R4: offset 0x23 reads signed oscillator error, 16 MHz at 5 V.
// R5: offset 0x24 reads signed oscillator error, 20 MHz at 3 V.
// R6: offset 0x25 reads signed oscillator error, 20 MHz at 5 V.
// R7: on reset, watchdog fuse upper nibble goes to the window field.
// R8: on reset, watchdog fuse lower nibble goes to the period field.
// R9: brown-out settings reload only after power-on; other resets keep them.
// R10: on reset, three-bit threshold level goes to second brown-out control.
// R11: on reset, sample rate bit goes to first brown-out control.
// R12: on reset, active-mode field goes to first brown-out control.
// R13: on reset, sleep-mode field goes to first brown-out control.
// R14: processor only reads fuses; programming port alone writes or clears them.
// R15: processor writes are ignored and change nothing.
// R16: reserved offsets read a fixed value with no side effect.
module signature_fuse_loader #(
    parameter logic [23:0] PART_ID = 24'h00_a5c3,        // arbitrary value
    parameter logic [79:0] SERIAL = 80'h0102_0304_0506_0708_090a, // arbitrary value
    parameter logic [7:0] OSC_ERR_16M_3V = 8'h03,        // arbitrary value
    parameter logic [7:0] OSC_ERR_16M_5V = 8'hfe,        // arbitrary value
    parameter logic [7:0] OSC_ERR_20M_3V = 8'h05,        // arbitrary value
    parameter logic [7:0] OSC_ERR_20M_5V = 8'hfa         // arbitrary value
) (
    // clock and resets
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic por_n,
    // processor access
    input wire logic cpu_rd_en,
    input wire fuse_sig_pkg::byte_req_s cpu_rd_req,
    input wire logic cpu_wr_en,
    input wire fuse_sig_pkg::byte_req_s cpu_wr_req,
    input wire fuse_sig_pkg::byte_t cpu_wr_data,
    output fuse_sig_pkg::byte_t cpu_rd_data_q,
    output logic cpu_rd_valid_q,
    output logic cpu_wr_ignored_q,
    // programming and debug port access
    input wire logic prog_rd_en,
    input wire fuse_sig_pkg::byte_req_s prog_rd_req,
    input wire logic prog_wr_en,
    input wire logic [3:0] prog_wr_idx,
    input wire fuse_sig_pkg::byte_t prog_wr_data,
    input wire logic prog_erase,
    output fuse_sig_pkg::byte_t prog_rd_data_q,
    output logic prog_rd_valid_q,
    output logic prog_done_q,
    output logic prog_refused_q,
    // loaded control fields
    output fuse_sig_pkg::wdt_cfg_s watchdog_control_reg_q,
    output fuse_sig_pkg::bod_first_s brownout_control_first_q,
    output logic [2:0] brownout_control_second_q,
    output logic load_done_q,
    // brown-out mode decodes
    output logic bod_active_on_q,
    output logic bod_sleep_on_q,
    output logic bod_wake_hold_q,
    output logic bod_sleep_rsvd_q,
    output logic bod_slow_sample_q,
    output logic bod_level_listed_q
);

    fuse_sig_pkg::byte_t fuse_q [fuse_sig_pkg::FUSE_COUNT];
    fuse_sig_pkg::load_e state_q;
    fuse_sig_pkg::load_e state_d;
    logic por_pending_q;
    logic por_pending_d;

    // the processor has no write port into the store; it only reads fuse_q
    fuse_store u_store (
        .ref_clk(ref_clk),
        .por_n(por_n),
        .wr_en(prog_wr_en), // [R14]
        .wr_idx(prog_wr_idx),
        .wr_data(prog_wr_data),
        .erase(prog_erase), // [R14]
        .fuse_q(fuse_q),
        .done_q(prog_done_q),
        .refused_q(prog_refused_q)
    );

    // signature row lookup; everything is a constant, so reads have no effect
    function automatic fuse_sig_pkg::byte_t sig_byte(input logic [5:0] a);
        logic [5:0] ser;
        ser = a - fuse_sig_pkg::OFS_SERIAL;
        if (a < fuse_sig_pkg::OFS_SERIAL) begin
            return PART_ID[8 * int'(a - fuse_sig_pkg::OFS_PART_ID) +: 8]; // [R1]
        end
        if (int'(ser) < fuse_sig_pkg::SERIAL_BYTES) begin
            return SERIAL[8 * int'(ser) +: 8]; // [R2]
        end
        if (a == fuse_sig_pkg::OFS_OSC_16M_3V) begin
            return OSC_ERR_16M_3V; // [R3]
        end
        if (a == fuse_sig_pkg::OFS_OSC_16M_5V) begin
            return OSC_ERR_16M_5V; // [R4]
        end
        if (a == fuse_sig_pkg::OFS_OSC_20M_3V) begin
            return OSC_ERR_20M_3V; // [R5]
        end
        if (a == fuse_sig_pkg::OFS_OSC_20M_5V) begin
            return OSC_ERR_20M_5V; // [R6]
        end
        return fuse_sig_pkg::RSVD_READ; // [R16]
    endfunction

    // fuse bank lookup; reserved and out-of-range offsets give the fixed value
    function automatic fuse_sig_pkg::byte_t fuse_byte(input logic [5:0] a);
        logic [3:0] idx;
        idx = a[3:0];
        if (a > 6'(fuse_sig_pkg::FUSE_LOCK)) begin
            return fuse_sig_pkg::RSVD_READ; // [R16]
        end
        if (!fuse_sig_pkg::fuse_mapped(idx)) begin
            return fuse_sig_pkg::RSVD_READ; // [R16]
        end
        return fuse_q[idx];
    endfunction

    function automatic fuse_sig_pkg::byte_t read_byte(input fuse_sig_pkg::byte_req_s r);
        if (r.space == fuse_sig_pkg::SPACE_FUSE) begin
            return fuse_byte(r.addr);
        end
        return sig_byte(r.addr);
    endfunction

    // read selection shared by both ports; a process, not a net, so a fuse
    // write is seen even while the requested address stands still
    fuse_sig_pkg::byte_t cpu_rd_sel;
    fuse_sig_pkg::byte_t prog_rd_sel;
    always_comb begin
        cpu_rd_sel = read_byte(cpu_rd_req);
        prog_rd_sel = read_byte(prog_rd_req);
    end

    // the watched fuse fields as the loader sees them
    wire fuse_sig_pkg::wdt_cfg_s wdt_fuse = fuse_q[fuse_sig_pkg::FUSE_WATCHDOG];
    wire fuse_sig_pkg::bod_fuse_s bod_fuse = fuse_q[fuse_sig_pkg::FUSE_BROWNOUT];

    // loader sequencing
    wire in_load_wdt = state_q == fuse_sig_pkg::ST_LOAD_WDT;
    wire in_load_bod = state_q == fuse_sig_pkg::ST_LOAD_BOD;
    wire take_bod = in_load_bod & por_pending_q;

    // brown-out mode decodes from the loaded copy
    wire active_on = brownout_control_first_q.active != fuse_sig_pkg::BOD_MODE_OFF;
    wire sleep_on = brownout_control_first_q.sleep inside {fuse_sig_pkg::BOD_MODE_ON,
                                                           fuse_sig_pkg::BOD_MODE_SAMPLED};
    wire wake_hold = brownout_control_first_q.active == fuse_sig_pkg::BOD_MODE_HOLD;
    wire sleep_rsvd = brownout_control_first_q.sleep == fuse_sig_pkg::BOD_MODE_HOLD;
    wire slow_sample = brownout_control_first_q.sample_rate == fuse_sig_pkg::BOD_RATE_125HZ;
    wire level_listed = brownout_control_second_q inside {fuse_sig_pkg::BOD_LVL_1V8,
                                                          fuse_sig_pkg::BOD_LVL_2V6,
                                                          fuse_sig_pkg::BOD_LVL_4V2};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fuse_sig_pkg::ST_LOAD_WDT: begin
                state_d = fuse_sig_pkg::ST_LOAD_BOD;
            end
            fuse_sig_pkg::ST_LOAD_BOD: begin
                state_d = fuse_sig_pkg::ST_READY;
            end
            fuse_sig_pkg::ST_READY: begin
                state_d = fuse_sig_pkg::ST_READY;
            end
            default: begin
                state_d = fuse_sig_pkg::ST_LOAD_WDT;
            end
        endcase
    end

    // a power-on leaves a pending mark that only the brown-out copy consumes
    always_comb begin
        por_pending_d = por_pending_q;
        if (take_bod) begin
            por_pending_d = 1'b0; // [R9]
        end
    end

    // every system reset restarts the load sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= fuse_sig_pkg::ST_LOAD_WDT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            load_done_q <= 1'b0;
        end else begin
            load_done_q <= state_d == fuse_sig_pkg::ST_READY;
        end
    end

    // watchdog copy happens on every system reset, not on a power-on alone
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_control_reg_q <= fuse_sig_pkg::wdt_cfg_s'(fuse_sig_pkg::WATCHDOG_FUSE_RST);
        end else if (in_load_wdt) begin
            watchdog_control_reg_q.window <= wdt_fuse.window; // [R7]
            watchdog_control_reg_q.period <= wdt_fuse.period; // [R8]
        end
    end

    // brown-out state lives on the power-on reset so a system reset keeps it
    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            por_pending_q <= 1'b1;
        end else begin
            por_pending_q <= por_pending_d; // [R9]
        end
    end

    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            brownout_control_second_q <= fuse_sig_pkg::BOD_LVL_1V8;
        end else if (take_bod) begin
            brownout_control_second_q <= bod_fuse.level; // [R9] [R10]
        end
    end

    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            brownout_control_first_q <= '0;
        end else if (take_bod) begin
            brownout_control_first_q.sample_rate <= bod_fuse.sample_rate; // [R11]
            brownout_control_first_q.active <= bod_fuse.active; // [R12]
            brownout_control_first_q.sleep <= bod_fuse.sleep; // [R13]
        end
    end

    // registered decodes so the outputs come from flops
    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            bod_active_on_q <= 1'b0;
            bod_sleep_on_q <= 1'b0;
            bod_wake_hold_q <= 1'b0;
        end else begin
            bod_active_on_q <= active_on; // [R12]
            bod_sleep_on_q <= sleep_on; // [R13]
            bod_wake_hold_q <= wake_hold; // [R12]
        end
    end

    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            bod_sleep_rsvd_q <= 1'b0;
            bod_slow_sample_q <= 1'b0;
            bod_level_listed_q <= 1'b1;
        end else begin
            bod_sleep_rsvd_q <= sleep_rsvd; // [R13]
            bod_slow_sample_q <= slow_sample; // [R11]
            bod_level_listed_q <= level_listed; // [R10]
        end
    end

    // processor reads: one cycle latency, data holds until the next read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rd_data_q <= fuse_sig_pkg::RSVD_READ;
            cpu_rd_valid_q <= 1'b0;
        end else begin
            cpu_rd_valid_q <= cpu_rd_en;
            if (cpu_rd_en) begin
                cpu_rd_data_q <= cpu_rd_sel; // [R14]
            end
        end
    end

    // processor writes only raise a one-cycle notice; no storage sees them
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_wr_ignored_q <= 1'b0;
        end else begin
            cpu_wr_ignored_q <= cpu_wr_en; // [R15]
        end
    end

    // programming port reads see the live store, including bytes not yet reloaded
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prog_rd_data_q <= fuse_sig_pkg::RSVD_READ;
            prog_rd_valid_q <= 1'b0;
        end else begin
            prog_rd_valid_q <= prog_rd_en;
            if (prog_rd_en) begin
                prog_rd_data_q <= prog_rd_sel;
            end
        end
    end

    // write address and data are accepted but deliberately unused
    wire unused_wr = ^{cpu_wr_req, cpu_wr_data};

endmodule

// File: sim/loader_chk.sv
`timescale 1ns/100ps
module loader_chk #(
    parameter logic [23:0] PART_ID = 24'h00_0000
) (
    // clock and resets
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic por_n,
    // requests
    input wire logic cpu_rd_en,
    input wire fuse_sig_pkg::byte_req_s cpu_rd_req,
    input wire logic cpu_wr_en,
    input wire logic prog_wr_en,
    input wire logic [3:0] prog_wr_idx,
    input wire logic prog_erase,
    // answers and loaded fields
    input wire fuse_sig_pkg::byte_t cpu_rd_data_q,
    input wire logic cpu_rd_valid_q,
    input wire logic cpu_wr_ignored_q,
    input wire logic prog_refused_q,
    input wire fuse_sig_pkg::bod_first_s brownout_control_first_q,
    input wire logic [2:0] brownout_control_second_q,
    input wire logic load_done_q,
    input wire logic bod_wake_hold_q,
    input wire logic bod_level_listed_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire sig_rd = cpu_rd_en && cpu_rd_req.space == fuse_sig_pkg::SPACE_SIG;
    wire [1:0] act_mode = brownout_control_first_q.active;
    logic [1:0] id_sel_q;
    // remembers which id byte was asked for, so the answer can be tied to it
    always_ff @(posedge ref_clk) begin
        id_sel_q <= cpu_rd_req.addr[1:0];
    end
    rd_answer_a: assert property (cpu_rd_en |=> cpu_rd_valid_q) else $error("read not answered");
    rd_quiet_a: assert property (!cpu_rd_en |=> !cpu_rd_valid_q) else $error("spurious read valid");
    wr_ignore_a: assert property (cpu_wr_en |=> cpu_wr_ignored_q) else $error("write not ignored");
    part_id_a: assert property (sig_rd && cpu_rd_req.addr < 6'h03 |=>
        cpu_rd_data_q == PART_ID[id_sel_q * 8 +: 8]) else $error("part id byte wrong");
    rsvd_sig_a: assert property (sig_rd && cpu_rd_req.addr inside {[6'h0d:6'h21]} |=>
        cpu_rd_data_q == fuse_sig_pkg::RSVD_READ) else $error("reserved read wrong");
    prog_refuse_a: assert property (disable iff (!por_n) prog_wr_en && !prog_erase &&
        prog_wr_idx inside {4'h3, 4'h4, 4'h9, [4'hb:4'hf]} |=> prog_refused_q) else $error("bad index taken");
    load_seq_a: assert property (nrst && !$past(nrst) |=> !load_done_q ##1 load_done_q)
        else $error("load sequence timing wrong");
    bod_keep_a: assert property (disable iff (!por_n) !nrst |=> $stable(brownout_control_first_q) &&
        $stable(brownout_control_second_q)) else $error("brown-out changed in system reset");
    wake_dec_a: assert property (disable iff (!por_n) bod_wake_hold_q == ($past(act_mode) == 2'h3))
        else $error("wake hold decode wrong");
    level_dec_a: assert property (disable iff (!por_n)
        bod_level_listed_q == ($past(brownout_control_second_q) inside {3'h0, 3'h2, 3'h7}))
        else $error("level decode wrong");
endmodule

bind signature_fuse_loader loader_chk #(.PART_ID(PART_ID)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .por_n(por_n), .cpu_rd_en(cpu_rd_en), .cpu_rd_req(cpu_rd_req),
    .cpu_wr_en(cpu_wr_en), .prog_wr_en(prog_wr_en), .prog_wr_idx(prog_wr_idx), .prog_erase(prog_erase),
    .cpu_rd_data_q(cpu_rd_data_q), .cpu_rd_valid_q(cpu_rd_valid_q), .cpu_wr_ignored_q(cpu_wr_ignored_q),
    .prog_refused_q(prog_refused_q), .brownout_control_first_q(brownout_control_first_q),
    .brownout_control_second_q(brownout_control_second_q), .load_done_q(load_done_q),
    .bod_wake_hold_q(bod_wake_hold_q), .bod_level_listed_q(bod_level_listed_q)
);

// File: sim/signature_fuse_loader_tb.sv
`timescale 1ns/100ps
module signature_fuse_loader_tb;
    localparam logic [23:0] ID_V = 24'h12_3456;
    localparam logic [79:0] SN_V = 80'ha1a2_a3a4_a5a6_a7a8_a9aa;
    localparam logic [31:0] OSC_V = 32'h8070_f10f;
    logic ref_clk, nrst, por_n, cpu_rd_en, cpu_wr_en, prog_rd_en, prog_wr_en, prog_erase;
    fuse_sig_pkg::byte_req_s cpu_rd_req, cpu_wr_req, prog_rd_req;
    fuse_sig_pkg::byte_t cpu_wr_data, prog_wr_data, cpu_rd_data_q, prog_rd_data_q;
    logic [3:0] prog_wr_idx;
    logic cpu_rd_valid_q, cpu_wr_ignored_q, prog_rd_valid_q, prog_done_q, prog_refused_q, load_done_q;
    fuse_sig_pkg::wdt_cfg_s watchdog_control_reg_q;
    fuse_sig_pkg::bod_first_s brownout_control_first_q;
    logic [2:0] brownout_control_second_q;
    logic bod_active_on_q, bod_sleep_on_q, bod_wake_hold_q, bod_sleep_rsvd_q, bod_slow_sample_q, bod_level_listed_q;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    signature_fuse_loader #(.PART_ID(ID_V), .SERIAL(SN_V), .OSC_ERR_16M_3V(OSC_V[7:0]),
        .OSC_ERR_16M_5V(OSC_V[15:8]), .OSC_ERR_20M_3V(OSC_V[23:16]), .OSC_ERR_20M_5V(OSC_V[31:24])) dut (
        .ref_clk(ref_clk), .nrst(nrst), .por_n(por_n),
        .cpu_rd_en(cpu_rd_en), .cpu_rd_req(cpu_rd_req), .cpu_wr_en(cpu_wr_en), .cpu_wr_req(cpu_wr_req),
        .cpu_wr_data(cpu_wr_data), .cpu_rd_data_q(cpu_rd_data_q), .cpu_rd_valid_q(cpu_rd_valid_q),
        .cpu_wr_ignored_q(cpu_wr_ignored_q), .prog_rd_en(prog_rd_en), .prog_rd_req(prog_rd_req),
        .prog_wr_en(prog_wr_en), .prog_wr_idx(prog_wr_idx), .prog_wr_data(prog_wr_data), .prog_erase(prog_erase),
        .prog_rd_data_q(prog_rd_data_q), .prog_rd_valid_q(prog_rd_valid_q), .prog_done_q(prog_done_q),
        .prog_refused_q(prog_refused_q), .watchdog_control_reg_q(watchdog_control_reg_q),
        .brownout_control_first_q(brownout_control_first_q), .brownout_control_second_q(brownout_control_second_q),
        .load_done_q(load_done_q), .bod_active_on_q(bod_active_on_q), .bod_sleep_on_q(bod_sleep_on_q),
        .bod_wake_hold_q(bod_wake_hold_q), .bod_sleep_rsvd_q(bod_sleep_rsvd_q),
        .bod_slow_sample_q(bod_slow_sample_q), .bod_level_listed_q(bod_level_listed_q)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // a run of under two hundred cycles is expected; far beyond means a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("timeout after %0d cycles", cycles);
            end_of_test();
        end
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // both read ports get the same request, so each is checked on every read
    task automatic rd(input logic fuse, input logic [5:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        cpu_rd_en <= 1'b1;
        prog_rd_en <= 1'b1;
        cpu_rd_req <= '{space: fuse_sig_pkg::space_e'(fuse), addr: a};
        prog_rd_req <= '{space: fuse_sig_pkg::space_e'(fuse), addr: a};
        @(posedge ref_clk);
        cpu_rd_en <= 1'b0;
        prog_rd_en <= 1'b0;
        #1;
        check8("cpu_rd_valid", 8'h01, {7'h00, cpu_rd_valid_q});
        check8("cpu_rd_data", exp, cpu_rd_data_q);
        check8("prog_rd_valid", 8'h01, {7'h00, prog_rd_valid_q});
        check8("prog_rd_data", exp, prog_rd_data_q);
    endtask

    task automatic pwr(input logic [3:0] idx, input logic [7:0] d, input logic ok, input logic er);
        @(posedge ref_clk);
        prog_wr_en <= !er;
        prog_erase <= er;
        prog_wr_idx <= idx;
        prog_wr_data <= d;
        @(posedge ref_clk);
        prog_wr_en <= 1'b0;
        prog_erase <= 1'b0;
        #1;
        check8("prog_done", {7'h00, ok}, {7'h00, prog_done_q});
        check8("prog_refused", {7'h00, !ok}, {7'h00, prog_refused_q});
    endtask

    task automatic do_reset(input logic sys, input logic por);
        @(posedge ref_clk);
        nrst <= !sys;
        por_n <= !por;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset_values();
        check8("watchdog_ctrl", 8'h00, watchdog_control_reg_q);
        check8("bod_first", 8'h00, {3'h0, brownout_control_first_q});
        check8("bod_second", 8'h00, {5'h00, brownout_control_second_q});
        check8("load_done", 8'h01, {7'h00, load_done_q});
        rd(1'b1, 6'h00, 8'h00);
        rd(1'b1, 6'h01, 8'h00);
        $display("test reset_values done");
    endtask

    task automatic t_signature();
        for (int i = 0; i < 3; i++) rd(1'b0, 6'(i), ID_V[8 * i +: 8]);
        for (int i = 0; i < 10; i++) rd(1'b0, 6'(3 + i), SN_V[8 * i +: 8]);
        rd(1'b0, 6'h22, OSC_V[7:0]);
        rd(1'b0, 6'h23, OSC_V[15:8]);
        rd(1'b0, 6'h24, OSC_V[23:16]);
        rd(1'b0, 6'h25, OSC_V[31:24]);
        rd(1'b0, 6'h0d, fuse_sig_pkg::RSVD_READ);
        rd(1'b0, 6'h21, fuse_sig_pkg::RSVD_READ);
        rd(1'b1, 6'h03, fuse_sig_pkg::RSVD_READ);
        rd(1'b1, 6'h09, fuse_sig_pkg::RSVD_READ);
        $display("test signature done");
    endtask

    task automatic t_cpu_write();
        @(posedge ref_clk);
        cpu_wr_en <= 1'b1;
        cpu_wr_req <= '{space: fuse_sig_pkg::SPACE_FUSE, addr: 6'h00};
        cpu_wr_data <= 8'hff;
        @(posedge ref_clk);
        cpu_wr_en <= 1'b0;
        #1;
        check8("cpu_wr_ignored", 8'h01, {7'h00, cpu_wr_ignored_q});
        rd(1'b1, 6'h00, 8'h00);
        check8("watchdog_ctrl", 8'h00, watchdog_control_reg_q);
        $display("test cpu_write done");
    endtask

    task automatic t_wdt_load();
        pwr(4'h0, 8'h5a, 1'b1, 1'b0);
        pwr(4'h3, 8'h11, 1'b0, 1'b0);
        pwr(4'h1, 8'hff, 1'b1, 1'b0);
        rd(1'b1, 6'h00, 8'h5a);
        do_reset(1'b1, 1'b0);
        check8("wdt_window", 8'h05, {4'h0, watchdog_control_reg_q.window});
        check8("wdt_period", 8'h0a, {4'h0, watchdog_control_reg_q.period});
        check8("bod_first", 8'h00, {3'h0, brownout_control_first_q});
        check8("bod_second", 8'h00, {5'h00, brownout_control_second_q});
        pwr(4'h0, 8'h00, 1'b1, 1'b1);
        rd(1'b1, 6'h05, fuse_sig_pkg::FUSE_ERASED);
        $display("test wdt_load done");
    endtask

    task automatic t_bod_load();
        logic [7:0] vals [3];
        vals = '{8'heb, 8'h5d, 8'h64};
        foreach (vals[i]) begin
            // power-on alone marks a pending reload that the next system reset consumes
            do_reset(1'b0, 1'b1);
            pwr(4'h1, vals[i], 1'b1, 1'b0);
            do_reset(1'b1, 1'b0);
            check8("bod_level", {5'h00, vals[i][7:5]}, {5'h00, brownout_control_second_q});
            check8("bod_rate", {7'h00, vals[i][4]}, {7'h00, brownout_control_first_q.sample_rate});
            check8("bod_active", {6'h00, vals[i][3:2]}, {6'h00, brownout_control_first_q.active});
            check8("bod_sleep", {6'h00, vals[i][1:0]}, {6'h00, brownout_control_first_q.sleep});
            check8("slow_sample", {7'h00, vals[i][4]}, {7'h00, bod_slow_sample_q});
            check8("wake_hold", {7'h00, vals[i][3:2] == 2'h3}, {7'h00, bod_wake_hold_q});
            check8("active_on", {7'h00, vals[i][3:2] != 2'h0}, {7'h00, bod_active_on_q});
            check8("sleep_on", {7'h00, vals[i][1:0] inside {2'h1, 2'h2}}, {7'h00, bod_sleep_on_q});
            check8("sleep_rsvd", {7'h00, vals[i][1:0] == 2'h3}, {7'h00, bod_sleep_rsvd_q});
            check8("level_listed", {7'h00, vals[i][7:5] inside {3'h0, 3'h2, 3'h7}}, {7'h00, bod_level_listed_q});
        end
        $display("test bod_load done");
    endtask

    initial begin
        nrst = 1'b0;
        por_n = 1'b0;
        {cpu_rd_en, cpu_wr_en, prog_rd_en, prog_wr_en, prog_erase} = 5'h00;
        cpu_rd_req = '0;
        cpu_wr_req = '0;
        prog_rd_req = '0;
        cpu_wr_data = 8'h00;
        prog_wr_data = 8'h00;
        prog_wr_idx = 4'h0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        t_reset_values();
        t_signature();
        t_cpu_write();
        t_wdt_load();
        t_bod_load();
        end_of_test();
    end
endmodule
